// File: regpol_pkg.sv
// constants, field layouts, access policies and carriers for the register bank
// assumes one clock, synchronous reset and a single-cycle request port
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package regpol_pkg;

    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 32;
    localparam int OFS_W    = 12;
    localparam int NUM_REGS = 8;
    localparam int IDX_W    = 3;

    // ------------------------------------------------------------------------
    // access policies
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        pol_rc   = 3'h0,
        pol_ro   = 3'h1,
        pol_rw   = 3'h2,
        pol_rwc  = 3'h3,
        pol_rw1c = 3'h4,
        pol_rw1s = 3'h5,
        pol_w1c  = 3'h6,
        pol_wo   = 3'h7
    } policy_e;

    // ------------------------------------------------------------------------
    // offsets and indexes
    // ------------------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_RC   = 12'h000;
    localparam logic [OFS_W-1:0] OFS_RO   = 12'h004;
    localparam logic [OFS_W-1:0] OFS_RW   = 12'h008;
    localparam logic [OFS_W-1:0] OFS_RWC  = 12'h00c;
    localparam logic [OFS_W-1:0] OFS_RW1C = 12'h010;
    localparam logic [OFS_W-1:0] OFS_RW1S = 12'h014;
    localparam logic [OFS_W-1:0] OFS_W1C  = 12'h018;
    localparam logic [OFS_W-1:0] OFS_WO   = 12'h01c;

    localparam logic [IDX_W-1:0] IDX_RC   = 3'h0;
    localparam logic [IDX_W-1:0] IDX_RO   = 3'h1;
    localparam logic [IDX_W-1:0] IDX_RW   = 3'h2;
    localparam logic [IDX_W-1:0] IDX_RWC  = 3'h3;
    localparam logic [IDX_W-1:0] IDX_RW1C = 3'h4;
    localparam logic [IDX_W-1:0] IDX_RW1S = 3'h5;
    localparam logic [IDX_W-1:0] IDX_W1C  = 3'h6;
    localparam logic [IDX_W-1:0] IDX_WO   = 3'h7;

    // ------------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------------
    localparam int HI_FIELD_HI = 31;
    localparam int HI_FIELD_LO = 15;
    localparam int RSVD_HI     = 14;
    localparam int RSVD_LO     = 8;

    // every bit from lo up to hi inclusive
    function automatic logic [DATA_W-1:0] field_mask(input int hi, input int lo);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int b = 0; b < DATA_W; b++)
        begin
            if (b >= lo && b <= hi)
                m[b] = 1'b1;
        end
        return m;
    endfunction : field_mask

    localparam logic [DATA_W-1:0] RSVD_RW  = field_mask(RSVD_HI, RSVD_LO);
    localparam logic [DATA_W-1:0] RESET_RW = 32'h0000_8000;
    localparam logic [DATA_W-1:0] RESET_WO = 32'h0000_0001;
    localparam logic [DATA_W-1:0] ZERO_W   = 32'h0000_0000;

    localparam policy_e REG_POLICY [NUM_REGS] = '{
        pol_rc, pol_ro, pol_rw, pol_rwc, pol_rw1c, pol_rw1s, pol_w1c, pol_wo};
    localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
        ZERO_W, ZERO_W, RESET_RW, ZERO_W, ZERO_W, ZERO_W, ZERO_W, RESET_WO};
    localparam logic [DATA_W-1:0] REG_RSVD [NUM_REGS] = '{
        ZERO_W, ZERO_W, RSVD_RW, ZERO_W, ZERO_W, ZERO_W, ZERO_W, ZERO_W};
    localparam logic [DATA_W-1:0] REG_DASH [NUM_REGS] = '{
        ZERO_W, ZERO_W, ZERO_W, ZERO_W, ZERO_W, ZERO_W, ZERO_W, ZERO_W};

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } bus_rsp_s;

    typedef struct packed {
        logic [DATA_W-1:0] rw_value;
        logic [DATA_W-1:0] set_value;
        logic [DATA_W-1:0] wo_value;
        logic              wo_strobe;
    } ctrl_out_s;

    typedef struct packed {
        logic              hit;
        logic [IDX_W-1:0]  idx;
    } dec_s;

endpackage : regpol_pkg

// File: field_cell.sv
// one 32-bit register whose bits follow a single access policy
// assumes at most one of wr_en and rd_en per cycle, synchronous reset
`timescale 1ns/100ps
module field_cell #(
    parameter regpol_pkg::policy_e             POLICY    = regpol_pkg::pol_rw,
    parameter logic [regpol_pkg::DATA_W-1:0]   RESET_VAL = '0,
    parameter logic [regpol_pkg::DATA_W-1:0]   RSVD_MASK = '0,
    parameter logic [regpol_pkg::DATA_W-1:0]   DASH_MASK = '0
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    input  wire logic [regpol_pkg::DATA_W-1:0] wdata,
    input  wire logic [regpol_pkg::DATA_W-1:0] hw_set,
    input  wire logic [regpol_pkg::DATA_W-1:0] hw_value,
    output logic      [regpol_pkg::DATA_W-1:0] q,
    output logic      [regpol_pkg::DATA_W-1:0] rdata
);
    import regpol_pkg::*;

    logic [DATA_W-1:0] next_q;
    logic [DATA_W-1:0] wmask;

    // ------------------------------------------------------------------------
    // next value per policy
    // ------------------------------------------------------------------------
    // hardware sets are or-ed in last so an event never loses to a clear
    always_comb
    begin
        wmask = wr_en ? wdata : '0;
        case (POLICY)
            pol_rc:   next_q = (rd_en ? '0 : q) | hw_set;
            pol_ro:   next_q = hw_value;
            pol_rw:   next_q = wr_en ? wdata : q;
            pol_rwc:  next_q = (wr_en ? '0 : q) | hw_set;
            pol_rw1c: next_q = (q & ~wmask) | hw_set;
            pol_rw1s: next_q = q | wmask;
            pol_w1c:  next_q = (q & ~wmask) | hw_set;
            pol_wo:   next_q = wr_en ? wdata : q;
            default:  next_q = q;
        endcase
        next_q = next_q & ~RSVD_MASK;
    end

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    // dash bits keep whatever they held; they have no defined reset value
    always_ff @(posedge mclk)
    begin
        if (rst)
            q <= (q & DASH_MASK) | (RESET_VAL & ~DASH_MASK & ~RSVD_MASK);
        else
            q <= next_q;
    end

    // ------------------------------------------------------------------------
    // read view
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (POLICY == pol_w1c || POLICY == pol_wo)
            rdata = '0;
        else
            rdata = q & ~RSVD_MASK;
    end

endmodule : field_cell

// File: register_field_access_policies.sv
// register bank holding one register of each field access policy
// assumes a single-cycle request port and synchronous active-high reset
`timescale 1ns/100ps
module register_field_access_policies #(
    parameter logic [regpol_pkg::ADDR_W-1:0] BASE_ADDR = 32'h0000_0000
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire regpol_pkg::bus_req_s          req,
    input  wire logic [regpol_pkg::DATA_W-1:0] hw_event,
    input  wire logic [regpol_pkg::DATA_W-1:0] ro_value,
    output regpol_pkg::bus_rsp_s               rsp,
    output regpol_pkg::ctrl_out_s              ctrl
);
    import regpol_pkg::*;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function automatic dec_s decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] ofs;
        dec_s              d;
        ofs   = addr - BASE_ADDR;
        d.hit = 1'b1;
        d.idx = IDX_RC;
        // anything beyond the 4 KiB window misses even if low bits match
        if (ofs[ADDR_W-1:OFS_W] != '0)
            d.hit = 1'b0;
        else if (ofs[OFS_W-1:0] == OFS_RC)
            d.idx = IDX_RC;
        else if (ofs[OFS_W-1:0] == OFS_RO)
            d.idx = IDX_RO;
        else if (ofs[OFS_W-1:0] == OFS_RW)
            d.idx = IDX_RW;
        else if (ofs[OFS_W-1:0] == OFS_RWC)
            d.idx = IDX_RWC;
        else if (ofs[OFS_W-1:0] == OFS_RW1C)
            d.idx = IDX_RW1C;
        else if (ofs[OFS_W-1:0] == OFS_RW1S)
            d.idx = IDX_RW1S;
        else if (ofs[OFS_W-1:0] == OFS_W1C)
            d.idx = IDX_W1C;
        else if (ofs[OFS_W-1:0] == OFS_WO)
            d.idx = IDX_WO;
        else
            d.hit = 1'b0;
        return d;
    endfunction : decode

    dec_s              dec;
    logic [NUM_REGS-1:0] wr_en;
    logic [NUM_REGS-1:0] rd_en;
    logic [DATA_W-1:0] q     [NUM_REGS];
    logic [DATA_W-1:0] rdata [NUM_REGS];

    always_comb
    begin
        dec   = decode(req.addr);
        wr_en = '0;
        rd_en = '0;
        if (req.valid && dec.hit)
        begin
            wr_en[dec.idx] = req.write;
            rd_en[dec.idx] = ~req.write;
        end
    end

    // ------------------------------------------------------------------------
    // register cells
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < NUM_REGS; i++)
    begin : g_reg
        field_cell #(
            .POLICY    (REG_POLICY[i]),
            .RESET_VAL (REG_RESET[i]),
            .RSVD_MASK (REG_RSVD[i]),
            .DASH_MASK (REG_DASH[i])
        ) u_cell (
            .mclk     (mclk),
            .rst      (rst),
            .wr_en    (wr_en[i]),
            .rd_en    (rd_en[i]),
            .wdata    (req.wdata),
            .hw_set   (hw_event),
            .hw_value (ro_value),
            .q        (q[i]),
            .rdata    (rdata[i])
        );
    end

    // ------------------------------------------------------------------------
    // read response
    // ------------------------------------------------------------------------
    // unmapped reads answer zero so software never sees stale data
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rsp.valid <= 1'b0;
            rsp.data  <= '0;
        end
        else
        begin
            rsp.valid <= req.valid & ~req.write;
            if (req.valid && !req.write && dec.hit)
                rsp.data <= rdata[dec.idx];
            else
                rsp.data <= '0;
        end
    end

    // ------------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------------
    // copies cost a cycle but keep every output straight from a flop
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl.rw_value  <= REG_RESET[IDX_RW] & ~REG_RSVD[IDX_RW];
            ctrl.set_value <= REG_RESET[IDX_RW1S];
            ctrl.wo_value  <= REG_RESET[IDX_WO];
            ctrl.wo_strobe <= 1'b0;
        end
        else
        begin
            ctrl.rw_value  <= q[IDX_RW];
            ctrl.set_value <= q[IDX_RW1S];
            ctrl.wo_value  <= q[IDX_WO];
            ctrl.wo_strobe <= wr_en[IDX_WO];
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_rc_read_clear: assert property (
        rd_en[IDX_RC] && hw_event == '0 |=> q[IDX_RC] == '0)
        else $error("read-clear field not cleared by read");

    a_rc_read_value: assert property (
        rd_en[IDX_RC] |=> rsp.valid && rsp.data == $past(q[IDX_RC]))
        else $error("read-clear read returned wrong value");

    a_rw_store_back: assert property (
        wr_en[IDX_RW] ##1 rd_en[IDX_RW]
        |=> rsp.data == ($past(req.wdata, 2) & ~RSVD_RW))
        else $error("read-write field did not read back written data");

    a_rwc_any_clear: assert property (
        wr_en[IDX_RWC] && hw_event == '0 |=> q[IDX_RWC] == '0)
        else $error("write-any-clear register not cleared");

    a_w1c_bitwise: assert property (
        wr_en[IDX_RW1C]
        |=> q[IDX_RW1C] == (($past(q[IDX_RW1C]) & ~$past(req.wdata)) | $past(hw_event)))
        else $error("write-one-clear changed wrong bits");

    a_w1s_bitwise: assert property (
        wr_en[IDX_RW1S] |=> q[IDX_RW1S] == ($past(q[IDX_RW1S]) | $past(req.wdata)))
        else $error("write-one-set changed wrong bits");

    a_w1s_no_loss: assert property (
        !wr_en[IDX_RW1S] |=> q[IDX_RW1S] == $past(q[IDX_RW1S]))
        else $error("write-one-set bit changed without a write");

    a_wo_read_zero: assert property (
        (rd_en[IDX_WO] || rd_en[IDX_W1C]) |=> rsp.valid && rsp.data == '0)
        else $error("write-only read returned data");

    a_wo_strobe: assert property (
        wr_en[IDX_WO] |=> (q[IDX_WO] == $past(req.wdata) && ctrl.wo_strobe)
            ##1 ctrl.wo_value == $past(req.wdata, 2))
        else $error("write-only register did not take write");

    a_rsvd_zero: assert property (
        (q[IDX_RW] & RSVD_RW) == '0 && (ctrl.rw_value & RSVD_RW) == '0)
        else $error("reserved bits not zero");

    a_rsvd_read_zero: assert property (
        rd_en[IDX_RW] |=> (rsp.data & RSVD_RW) == '0)
        else $error("reserved bits read back nonzero");

    a_unmapped_zero: assert property (
        req.valid && !req.write && !dec.hit |=> rsp.valid && rsp.data == '0)
        else $error("unmapped read returned data");

    a_field_range: assert property (
        wr_en[IDX_RW] && req.wdata == '1
        |=> q[IDX_RW] == ~RSVD_RW
            && q[IDX_RW][HI_FIELD_HI:HI_FIELD_LO] == '1)
        else $error("bit range not fully stored");

    // reset check runs outside the default disable
    a_reset_value: assert property (@(posedge mclk) disable iff (1'b0)
        rst |=> q[IDX_RW] == (RESET_RW & ~RSVD_RW) && q[IDX_WO] == RESET_WO
            && q[IDX_RC] == '0 && !rsp.valid)
        else $error("register not at reset value");

    c_rc_read_event: cover property (rd_en[IDX_RC] && hw_event != '0);
    c_w1c_ack: cover property (wr_en[IDX_RW1C] && (req.wdata & q[IDX_RW1C]) != '0);
    c_wo_write: cover property (wr_en[IDX_WO] ##1 ctrl.wo_strobe);
    c_unmapped: cover property (req.valid && !dec.hit);

endmodule : register_field_access_policies

// File: tb_register_field_access_policies.sv
// self-checking bench for the register bank: directed corners, then seeded random traffic
// assumes the bank's package, one clock, synchronous active-high reset, no other model
`timescale 1ns/100ps
module tb_register_field_access_policies;
    import regpol_pkg::*;

    // ------------------------------------------------------------------------
    // signals and bench model
    // ------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] BASE = 32'h4002_c000;
    logic              mclk;
    logic              rst;
    bus_req_s          req;
    logic [DATA_W-1:0] hw_event;
    logic [DATA_W-1:0] ro_value;
    bus_rsp_s          rsp;
    ctrl_out_s         ctrl;
    logic [DATA_W-1:0] m [NUM_REGS];
    bus_req_s          p_req;
    logic [DATA_W-1:0] p_hw;
    logic [DATA_W-1:0] p_ro;
    logic [DATA_W-1:0] last_rd;
    logic [31:0]       seed;
    int                err_count;
    int                checks;
    int                wo_writes;
    int                strobes;

    register_field_access_policies #(.BASE_ADDR(BASE)) dut_u (
        .mclk     (mclk),
        .rst      (rst),
        .req      (req),
        .hw_event (hw_event),
        .ro_value (ro_value),
        .rsp      (rsp),
        .ctrl     (ctrl)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // strobe sampled mid-cycle, well clear of the edge
    always @(negedge mclk)
        if (ctrl.wo_strobe === 1'b1) strobes++;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [ADDR_W-1:0] at(input logic [OFS_W-1:0] ofs);
        return BASE + {20'h0, ofs};
    endfunction : at

    function automatic int reg_of(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] o;
        o = a - BASE;
        if (o < 32'h20 && o[1:0] == 2'b00) return int'(o[4:2]);
        return -1;
    endfunction : reg_of

    task automatic cmp32(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : cmp32

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : cmp1

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------------
    // model of the request taken at the last edge
    // ------------------------------------------------------------------------
    task automatic apply(output logic ev, output logic [DATA_W-1:0] ed);
        int i;
        i = reg_of(p_req.addr);
        ev = p_req.valid & ~p_req.write;
        ed = '0;
        // write-only kinds and holes read back as zero
        if (ev && i >= 0 && i <= 5) ed = m[i];
        if (ev && i == 0) m[0] = '0;
        if (p_req.valid && p_req.write)
            case (i)
                2: m[2] = p_req.wdata & ~RSVD_RW;
                3: m[3] = '0;
                4, 6: m[i] = m[i] & ~p_req.wdata;
                5: m[5] = m[5] | p_req.wdata;
                7:
                begin
                    m[7] = p_req.wdata;
                    wo_writes++;
                end
                default: ;
            endcase
        // hardware set wins over a software clear in the same cycle
        m[0] = m[0] | p_hw;
        m[3] = m[3] | p_hw;
        m[4] = m[4] | p_hw;
        m[6] = m[6] | p_hw;
        m[1] = p_ro;
    endtask : apply

    // one request a cycle; results of the previous one are checked after the edge
    task automatic step(input logic v, input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] hw);
        logic              ev;
        logic [DATA_W-1:0] ed;
        logic [DATA_W-1:0] nro;
        nro = rnd();
        @(posedge mclk);
        req <= '{valid: v, write: w, addr: a, wdata: d};
        hw_event <= hw;
        ro_value <= nro;
        #1;
        apply(ev, ed);
        cmp1(rsp.valid, ev);
        cmp32(rsp.data, ed);
        last_rd = rsp.data;
        p_req = '{valid: v, write: w, addr: a, wdata: d};
        p_hw = hw;
        p_ro = nro;
    endtask : step

    // two idle cycles so the registered copies have caught up
    task automatic chk_ctrl();
        step(1'b0, 1'b0, '0, '0, '0);
        step(1'b0, 1'b0, '0, '0, '0);
        cmp32(ctrl.rw_value, m[2]);
        cmp32(ctrl.set_value, m[5]);
        cmp32(ctrl.wo_value, m[7]);
    endtask : chk_ctrl

    task automatic do_reset(input int n);
        @(posedge mclk);
        rst <= 1'b1;
        req <= '0;
        hw_event <= '0;
        ro_value <= '0;
        repeat (n) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < NUM_REGS; i++) m[i] = REG_RESET[i];
        p_req = '0;
        p_hw = '0;
        p_ro = '0;
        #1;
        cmp1(rsp.valid, 1'b0);
        cmp32(ctrl.rw_value, REG_RESET[IDX_RW]);
        cmp32(ctrl.wo_value, REG_RESET[IDX_WO]);
        cmp1(ctrl.wo_strobe, 1'b0);
    endtask : do_reset

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        logic [31:0]       r;
        logic [ADDR_W-1:0] a;
        seed = 32'hed06;
        err_count = 0;
        checks = 0;
        wo_writes = 0;
        strobes = 0;
        rst = 1'b1;
        req = '0;
        hw_event = '0;
        ro_value = '0;
        do_reset(5);
        for (int i = 0; i < NUM_REGS; i++) step(1'b1, 1'b0, at(OFS_W'(4 * i)), '0, '0);
        step(1'b1, 1'b1, at(OFS_RW), 32'hffff_ffff, '0);
        step(1'b1, 1'b1, at(OFS_RO), REG_RESET[IDX_RO], 32'h0000_00a5);
        step(1'b1, 1'b0, at(OFS_RW), '0, 32'h0000_0100);
        step(1'b1, 1'b0, at(OFS_RC), '0, '0);
        step(1'b1, 1'b0, at(OFS_RC), '0, '0);
        step(1'b1, 1'b1, at(OFS_RWC), 32'h0000_0000, '0);
        step(1'b1, 1'b0, at(OFS_RWC), '0, '0);
        step(1'b1, 1'b1, at(OFS_RW1C), 32'h0000_000f, 32'h0000_00f0);
        step(1'b1, 1'b0, at(OFS_RW1C), '0, 32'h0000_0200);
        step(1'b0, 1'b0, '0, '0, '0);
        step(1'b1, 1'b1, at(OFS_RW1C), last_rd, '0);
        step(1'b1, 1'b0, at(OFS_RW1C), '0, '0);
        step(1'b1, 1'b1, at(OFS_W1C), 32'h0000_0004, 32'h0000_003c);
        step(1'b1, 1'b0, at(OFS_W1C), '0, '0);
        step(1'b1, 1'b1, at(OFS_RW1S), 32'h0000_0011, 32'hffff_0000);
        step(1'b1, 1'b1, at(OFS_RW1S), 32'h0000_0000, '0);
        step(1'b1, 1'b1, at(OFS_RW1S), 32'h8000_0100, '0);
        step(1'b1, 1'b0, at(OFS_RW1S), '0, '0);
        step(1'b1, 1'b1, at(OFS_WO), 32'h1234_5678, '0);
        step(1'b1, 1'b1, at(OFS_WO), 32'h0bad_f00d, '0);
        step(1'b1, 1'b0, at(OFS_WO), '0, '0);
        step(1'b1, 1'b1, BASE + 32'h0000_1008, 32'h0000_0000, '0);
        step(1'b1, 1'b1, BASE - 32'h0000_0004, 32'h0000_0000, '0);
        step(1'b1, 1'b0, at(12'h020), '0, '0);
        step(1'b1, 1'b0, BASE + 32'h0000_1008, '0, '0);
        step(1'b1, 1'b0, at(OFS_RW), '0, '0);
        chk_ctrl();
        for (int n = 0; n < 3000; n++)
        begin
            r = rnd();
            a = (r[15:13] == 3'h7) ? at(12'h040) : at({7'h0, r[10:8], 2'b00});
            // read-only fields only ever get their reset value written
            if (reg_of(a) == 1)
                step(r[0] | r[1], r[2], a, REG_RESET[IDX_RO], rnd() & rnd() & rnd());
            else
                step(r[0] | r[1], r[2], a, rnd(), rnd() & rnd() & rnd());
            if (r[20:16] == 5'h0) chk_ctrl();
            if (n == 1500)
            begin
                chk_ctrl();
                do_reset(2);
            end
        end
        chk_ctrl();
        cmp32(DATA_W'(strobes), DATA_W'(wo_writes));
        report_and_stop();
    end

    // guards against a hung sequence
    initial
    begin
        repeat (100000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end

endmodule : tb_register_field_access_policies
